// File: ilv_irq_ctrl.sv
// Purpose: Interrupt request/enable registers, pin edge detection, supply monitor digital side
// Assumes: Pins and event inputs synchronous to pclk; comparator result given as a level
// Notes: 8-bit registers in low bits of APB words; no wait states
//
// Behaviour
// R1 - Bits 2:0 of monitor control select one of eight thresholds, 1.8V to 4.0V
// R2 - Read-only bit 5 shows low supply while below threshold
// R3 - Bit 4 turns the monitor on; clearing it switches circuits off
// R4 - Monitor forced off in sleep even when enabled
// R5 - Bits 7:6 pick qualify width 1-2, 3-4, 7-8, 1-2 slow ticks
// R6 - Low supply flag sets only after qualify width elapses
// R7 - Low supply flag wakes from idle; software presets flag to avoid it
// R8 - Software waits stabilisation time before trusting the output bit
// R9 - Two-bit edge field per pin: off, rising, falling, both
// R10 - Edge fields packed in two registers, upper bits of second read zero
// R11 - Selected pin edge sets pin flag; internal events set own flags
// R12 - Each source has enable and flag; serviced when both and global set
// R13 - First primary register holds converter, pin 0/1 flags, enables, global
// R14 - Four shared group requests with flags 7:4 and enables 3:0
// R15 - Four group registers hold timer, monitor, eeprom and pin 2/3 pairs
// R16 - Bit 3 of monitor control reads zero, writes ignored
// R17 - All control bits, edge fields, flags and enables reset to zero
// R18 - Software clears group sub-source flags itself
// R19 - Group request asserted when any sub-source has flag and enable
// R20 - Pins synchronised before edge detection so one edge sets once
module ilv_irq_ctrl
  import ilv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] ext_irq_pin,
  input wire logic below_threshold,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic converter_event,
  input wire logic [1:0] timebase_event,
  input wire logic [1:0] serial_port_event,
  input wire logic serial_module_event,
  input wire logic [3:0] periodic_timer_event,
  input wire logic eeprom_event,
  input wire logic [1:0] std_timer_event,
  input wire logic [2:0] adv_timer_event,
  output logic [2:0] threshold_select,
  output logic monitor_active,
  output logic irq_request,
  output logic [14:0] source_request,
  output logic idle_wake
);
  // ==========================================================
  // Register storage
  logic [7:0] monitor_ctrl_reg;
  logic [7:0] edge_lo_reg;
  logic [7:0] edge_hi_reg;
  logic [7:0] prim_a_reg;
  logic [7:0] prim_b_reg;
  logic [7:0] prim_c_reg;
  logic [7:0] prim_d_reg;
  logic [7:0] grp_a_reg;
  logic [7:0] grp_b_reg;
  logic [7:0] grp_c_reg;
  logic [7:0] grp_d_reg;
  logic low_supply_out_reg;
  logic [5:0] pin_sync1_reg;
  logic [5:0] pin_sync2_reg;
  logic [5:0] pin_prev_reg;
  logic [15:0] slow_div_reg;
  logic [3:0] qualify_cnt_reg;
  logic qualify_done_reg;

  logic wr_en;
  logic slow_tick;
  logic [5:0] pin_hit;
  logic [15:0] edge_fields;
  logic [3:0] group_req;
  logic low_supply_set;
  logic [3:0] qualify_limit;

  // ==========================================================
  // Helpers
  function automatic logic edge_match(input logic [1:0] sel, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = prev & ~now;
    unique case (sel)
      EDGE_OFF: edge_match = 1'b0;
      EDGE_RISE: edge_match = rise;
      EDGE_FALL: edge_match = fall;
      EDGE_BOTH: edge_match = rise | fall;
    endcase
  endfunction : edge_match

  // Write data merged with hardware set; set wins over software clear
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic hit, input logic [7:0] wdata,
                                       input logic [7:0] mask, input logic [7:0] hw_set);
    merge = ((hit ? (wdata & mask) : cur) | hw_set) & mask;
  endfunction : merge

  function automatic logic any_pair(input logic [7:0] r);
    any_pair = |(r[7:4] & r[3:0]);
  endfunction : any_pair

  // ==========================================================
  // APB slave: zero wait, unmapped reads zero, no error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;

  always_comb
  begin
    unique case (paddr)
      OFS_SUPPLY_MONITOR_CTRL: prdata = {24'h0, monitor_ctrl_reg[7:6], low_supply_out_reg,
                                         monitor_ctrl_reg[4], 1'b0, monitor_ctrl_reg[2:0]}; // R2 R16
      OFS_PIN_EDGE_SELECT_LO: prdata = {24'h0, edge_lo_reg};
      OFS_PIN_EDGE_SELECT_HI: prdata = {24'h0, edge_hi_reg}; // R10
      OFS_PRIMARY_IRQ_CTRL_A: prdata = {24'h0, prim_a_reg};
      OFS_PRIMARY_IRQ_CTRL_B: prdata = {24'h0, prim_b_reg};
      OFS_PRIMARY_IRQ_CTRL_C: prdata = {24'h0, prim_c_reg};
      OFS_PRIMARY_IRQ_CTRL_D: prdata = {24'h0, prim_d_reg};
      OFS_GROUP_IRQ_CTRL_A: prdata = {24'h0, grp_a_reg};
      OFS_GROUP_IRQ_CTRL_B: prdata = {24'h0, grp_b_reg};
      OFS_GROUP_IRQ_CTRL_C: prdata = {24'h0, grp_c_reg};
      OFS_GROUP_IRQ_CTRL_D: prdata = {24'h0, grp_d_reg};
      default: prdata = 32'h0;
    endcase
  end

  // ==========================================================
  // Supply monitor
  assign threshold_select = monitor_ctrl_reg[2:0]; // R1
  assign monitor_active = monitor_ctrl_reg[POS_MONITOR_ENABLE] & ~sleep_mode; // R3 R4

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      monitor_ctrl_reg <= RESET_VALUE; // R17
    else if (wr_en && paddr == OFS_SUPPLY_MONITOR_CTRL)
      monitor_ctrl_reg <= pwdata[7:0] & MASK_SUPPLY_MONITOR_CTRL; // R16
  end

  // Output bit follows comparator only while monitor runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_supply_out_reg <= 1'b0;
    else
      low_supply_out_reg <= monitor_active & below_threshold; // R2
  end

  // Slow oscillator tick from divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slow_div_reg <= 16'h0;
    else if (slow_tick)
      slow_div_reg <= 16'h0;
    else
      slow_div_reg <= slow_div_reg + 16'h1;
  end
  assign slow_tick = (slow_div_reg == 16'(SLOW_TICK_CYCLES - 1));

  always_comb
  begin
    unique case (monitor_ctrl_reg[POS_QUALIFY_LSB +: 2])
      2'h1: qualify_limit = QUAL_TICKS_MID; // R5
      2'h2: qualify_limit = QUAL_TICKS_LONG;
      default: qualify_limit = QUAL_TICKS_SHORT;
    endcase
  end

  // Low level must persist; tick phase gives the range width
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qualify_cnt_reg <= 4'h0;
      qualify_done_reg <= 1'b0;
    end
    else if (!low_supply_out_reg)
    begin
      qualify_cnt_reg <= 4'h0;
      qualify_done_reg <= 1'b0;
    end
    else if (slow_tick && qualify_cnt_reg < qualify_limit)
      qualify_cnt_reg <= qualify_cnt_reg + 4'h1;
    else if (qualify_cnt_reg >= qualify_limit)
      qualify_done_reg <= 1'b1; // R6
  end
  assign low_supply_set = (qualify_cnt_reg >= qualify_limit) & ~qualify_done_reg & low_supply_out_reg; // R6

  // ==========================================================
  // External pins: two-stage sync then edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync1_reg <= 6'h0;
      pin_sync2_reg <= 6'h0;
      pin_prev_reg <= 6'h0;
    end
    else
    begin
      pin_sync1_reg <= ext_irq_pin; // R20
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg <= pin_sync2_reg;
    end
  end

  assign edge_fields = {edge_hi_reg[3:0], edge_lo_reg}; // R10

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_pin
      assign pin_hit[gi] = edge_match(edge_fields[2*gi +: 2], pin_prev_reg[gi], pin_sync2_reg[gi]); // R9 R11
    end
  endgenerate

  // ==========================================================
  // Edge select registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_lo_reg <= RESET_VALUE; // R17
      edge_hi_reg <= RESET_VALUE;
    end
    else if (wr_en)
    begin
      if (paddr == OFS_PIN_EDGE_SELECT_LO)
        edge_lo_reg <= pwdata[7:0];
      if (paddr == OFS_PIN_EDGE_SELECT_HI)
        edge_hi_reg <= pwdata[7:0] & MASK_PIN_EDGE_SELECT_HI; // R10
    end
  end

  // ==========================================================
  // Primary registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prim_a_reg <= RESET_VALUE; // R17
      prim_b_reg <= RESET_VALUE;
      prim_c_reg <= RESET_VALUE;
      prim_d_reg <= RESET_VALUE;
    end
    else
    begin
      prim_a_reg <= merge(prim_a_reg, wr_en && paddr == OFS_PRIMARY_IRQ_CTRL_A, pwdata[7:0],
                          MASK_PRIMARY_IRQ_CTRL_A, {1'b0, converter_event, pin_hit[1:0], 4'h0}); // R11 R13
      prim_b_reg <= merge(prim_b_reg, wr_en && paddr == OFS_PRIMARY_IRQ_CTRL_B, pwdata[7:0],
                          8'hff, {group_req, 4'h0}); // R14 R19
      prim_c_reg <= merge(prim_c_reg, wr_en && paddr == OFS_PRIMARY_IRQ_CTRL_C, pwdata[7:0],
                          8'hff, {pin_hit[5:4], timebase_event, 4'h0}); // R11
      prim_d_reg <= merge(prim_d_reg, wr_en && paddr == OFS_PRIMARY_IRQ_CTRL_D, pwdata[7:0],
                          MASK_PRIMARY_IRQ_CTRL_D, {1'b0, serial_module_event, serial_port_event, 4'h0});
    end
  end

  // ==========================================================
  // Group registers; flags cleared only by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grp_a_reg <= RESET_VALUE; // R17
      grp_b_reg <= RESET_VALUE;
      grp_c_reg <= RESET_VALUE;
      grp_d_reg <= RESET_VALUE;
    end
    else
    begin
      grp_a_reg <= merge(grp_a_reg, wr_en && paddr == OFS_GROUP_IRQ_CTRL_A, pwdata[7:0],
                         8'hff, {periodic_timer_event, 4'h0}); // R15 R18
      grp_b_reg <= merge(grp_b_reg, wr_en && paddr == OFS_GROUP_IRQ_CTRL_B, pwdata[7:0],
                         8'hff, {low_supply_set, eeprom_event, std_timer_event, 4'h0}); // R6 R15
      grp_c_reg <= merge(grp_c_reg, wr_en && paddr == OFS_GROUP_IRQ_CTRL_C, pwdata[7:0],
                         MASK_GROUP_IRQ_CTRL_C, {1'b0, adv_timer_event, 4'h0}); // R15
      grp_d_reg <= merge(grp_d_reg, wr_en && paddr == OFS_GROUP_IRQ_CTRL_D, pwdata[7:0],
                         MASK_GROUP_IRQ_CTRL_D, {2'h0, pin_hit[3:2], 4'h0}); // R11 R15
    end
  end

  // ==========================================================
  // Request outputs
  assign group_req = {any_pair(grp_d_reg), any_pair(grp_c_reg), any_pair(grp_b_reg), any_pair(grp_a_reg)}; // R19

  // Order: a[2:0] pins0/1+conv, b[6:3] groups, c[10:7], d[13:11], 14 unused zero
  assign source_request = {1'b0,
                           prim_d_reg[6:4] & prim_d_reg[2:0],
                           prim_c_reg[7:4] & prim_c_reg[3:0],
                           prim_b_reg[7:4] & prim_b_reg[3:0],
                           prim_a_reg[6:4] & prim_a_reg[3:1]}; // R12 R14
  assign irq_request = prim_a_reg[POS_GLOBAL_IRQ_ENABLE] & (|source_request); // R12

  // Flag rising while idle wakes core; preset flag gives no new set
  assign idle_wake = idle_mode & low_supply_set & ~grp_b_reg[POS_LOW_SUPPLY_IRQ_FLAG]; // R7
endmodule : ilv_irq_ctrl

// File: ilv_irq_ctrl_properties.sv
// Purpose: Port checker for the interrupt and supply monitor block
// Assumes: pready fixed high, prdata combinational from registers
// Notes: Bound into every ilv_irq_ctrl instance
// ====================
// Checker
module ilv_irq_ctrl_properties
  import ilv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [5:0] ext_irq_pin,
  input wire logic below_threshold,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic converter_event,
  input wire logic [2:0] threshold_select,
  input wire logic monitor_active,
  input wire logic irq_request,
  input wire logic [14:0] source_request,
  input wire logic idle_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  a_thr_write:
    assert property (wr_en && paddr == OFS_SUPPLY_MONITOR_CTRL |=> threshold_select == $past(pwdata[2:0]))
      else $error("threshold select not taken from write");
  a_low_out_cause:
    assert property (rd_en && paddr == OFS_SUPPLY_MONITOR_CTRL && prdata[5] |-> $past(below_threshold))
      else $error("low supply bit without low supply");
  a_enable_write:
    assert property (wr_en && paddr == OFS_SUPPLY_MONITOR_CTRL |=> monitor_active == ($past(pwdata[4]) && !sleep_mode))
      else $error("monitor enable not following write");
  a_sleep_off:
    assert property (sleep_mode |-> !monitor_active)
      else $error("monitor active in sleep");
  a_conv_cause:
    assert property ($rose(source_request[2]) |-> $past(converter_event) || $past(wr_en))
      else $error("converter request without event");
  a_pin_sync:
    assert property ($rose(source_request[0]) |-> $past(wr_en) || ($past(ext_irq_pin[0], 2) != $past(ext_irq_pin[0], 4)))
      else $error("pin request without pin edge");
  a_irq_cause:
    assert property (irq_request |-> (|source_request[13:0]))
      else $error("request without enabled source");
  a_ctrl_rsvd:
    assert property (rd_en && paddr == OFS_SUPPLY_MONITOR_CTRL |-> prdata[3] == 1'b0)
      else $error("monitor ctrl bit 3 not zero");
  a_edge_hi_rsvd:
    assert property (rd_en && paddr == OFS_PIN_EDGE_SELECT_HI |-> prdata[7:4] == 4'h0)
      else $error("edge select upper bits not zero");
  a_prim_a_rsvd:
    assert property (rd_en && paddr == OFS_PRIMARY_IRQ_CTRL_A |-> prdata[7] == 1'b0)
      else $error("primary a bit 7 not zero");
  a_wake_idle:
    assert property (idle_wake |-> idle_mode)
      else $error("wake outside idle");
  c_wake: cover property (idle_wake);
  c_irq: cover property (irq_request);
  c_sleep: cover property (sleep_mode && $past(monitor_active));
endmodule : ilv_irq_ctrl_properties

bind ilv_irq_ctrl ilv_irq_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .ext_irq_pin(ext_irq_pin), .below_threshold(below_threshold), .sleep_mode(sleep_mode),
  .idle_mode(idle_mode), .converter_event(converter_event), .threshold_select(threshold_select),
  .monitor_active(monitor_active), .irq_request(irq_request), .source_request(source_request),
  .idle_wake(idle_wake));

// File: ilv_pkg.sv
// Purpose: Constants for the interrupt and supply monitor control block
// Assumes: APB, 32-bit data, one aligned word per 8-bit register
// Notes: Offsets are byte addresses
package ilv_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_SUPPLY_MONITOR_CTRL = 8'h00;
  localparam logic [7:0] OFS_PIN_EDGE_SELECT_LO = 8'h04;
  localparam logic [7:0] OFS_PIN_EDGE_SELECT_HI = 8'h08;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_A = 8'h0c;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_B = 8'h10;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_C = 8'h14;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_D = 8'h18;
  localparam logic [7:0] OFS_GROUP_IRQ_CTRL_A = 8'h1c;
  localparam logic [7:0] OFS_GROUP_IRQ_CTRL_B = 8'h20;
  localparam logic [7:0] OFS_GROUP_IRQ_CTRL_C = 8'h24;
  localparam logic [7:0] OFS_GROUP_IRQ_CTRL_D = 8'h28;
  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] MASK_SUPPLY_MONITOR_CTRL = 8'hd7;
  localparam logic [7:0] MASK_PIN_EDGE_SELECT_HI = 8'h0f;
  localparam logic [7:0] MASK_PRIMARY_IRQ_CTRL_A = 8'h7f;
  localparam logic [7:0] MASK_PRIMARY_IRQ_CTRL_D = 8'h77;
  localparam logic [7:0] MASK_GROUP_IRQ_CTRL_C = 8'h77;
  localparam logic [7:0] MASK_GROUP_IRQ_CTRL_D = 8'h33;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // ==========================================================
  // Field positions
  localparam int POS_LOW_SUPPLY_OUT = 5;
  localparam int POS_MONITOR_ENABLE = 4;
  localparam int POS_QUALIFY_LSB = 6;
  localparam int POS_LOW_SUPPLY_IRQ_FLAG = 7;
  localparam int POS_LOW_SUPPLY_IRQ_ENABLE = 3;
  localparam int POS_GLOBAL_IRQ_ENABLE = 0;
  // Edge field codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Qualify width, in slow oscillator ticks (upper bound of each range)
  localparam logic [3:0] QUAL_TICKS_SHORT = 4'h2;
  localparam logic [3:0] QUAL_TICKS_MID = 4'h4;
  localparam logic [3:0] QUAL_TICKS_LONG = 4'h8;
  // Slow oscillator tick: 32 kHz from 250 MHz pclk
  localparam int PCLK_HZ = 250000000;
  localparam int SLOW_OSC_HZ = 32000;
  localparam int SLOW_TICK_CYCLES = PCLK_HZ / SLOW_OSC_HZ;
endpackage : ilv_pkg

// File: ilv_src_model.sv
// Purpose: Pins and peripheral event sources facing the block
// Assumes: Events are single pclk pulses
// Notes: Driven after rising edges only, so the block never races them
// ====================
// Source model
module ilv_src_model (
  input wire logic pclk,
  output logic [5:0] ext_irq_pin,
  output logic converter_event,
  output logic [1:0] timebase_event,
  output logic [1:0] serial_port_event,
  output logic serial_module_event,
  output logic [3:0] periodic_timer_event,
  output logic eeprom_event,
  output logic [1:0] std_timer_event,
  output logic [2:0] adv_timer_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ev = 16'h0000;
  initial ext_irq_pin = 6'h00;
  assign {adv_timer_event, std_timer_event, eeprom_event, periodic_timer_event, serial_module_event,
    serial_port_event, timebase_event, converter_event} = ev;
  // One cycle wide, as internal sources raise them
  task pulse(input logic [15:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 16'h0000;
  endtask : pulse
  task pins(input logic [5:0] v);
    @(posedge pclk);
    ext_irq_pin <= v;
  endtask : pins
endmodule : ilv_src_model

// File: testbench.sv
// Purpose: Self-checking bench for the interrupt and supply monitor block
// Assumes: Zero wait APB slave, slow tick of SLOW_TICK_CYCLES
// Notes: Qualify codes 3 and 2 only, to keep the run short
module testbench
  import ilv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MASKS [11] = '{8'hd7, 8'hff, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'h77, 8'hff, 8'hff, 8'h77, 8'h33};
  logic pclk, presetn, psel, penable, pwrite, below_threshold, sleep_mode, idle_mode, woke;
  logic pready, pslverr, monitor_active, irq_request, idle_wake;
  logic converter_event, serial_module_event, eeprom_event;
  logic [1:0] timebase_event, serial_port_event, std_timer_event;
  logic [2:0] threshold_select, adv_timer_event;
  logic [3:0] periodic_timer_event;
  logic [5:0] ext_irq_pin;
  logic [7:0] paddr;
  logic [14:0] source_request;
  logic [31:0] pwdata, prdata, rd;
  int failures = 0;
  int tests_run = 0;
  ilv_src_model pm (.pclk(pclk), .ext_irq_pin(ext_irq_pin), .converter_event(converter_event),
    .timebase_event(timebase_event), .serial_port_event(serial_port_event),
    .serial_module_event(serial_module_event), .periodic_timer_event(periodic_timer_event),
    .eeprom_event(eeprom_event), .std_timer_event(std_timer_event), .adv_timer_event(adv_timer_event));
  ilv_irq_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .below_threshold(below_threshold), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .converter_event(converter_event), .timebase_event(timebase_event),
    .serial_port_event(serial_port_event), .serial_module_event(serial_module_event),
    .periodic_timer_event(periodic_timer_event), .eeprom_event(eeprom_event),
    .std_timer_event(std_timer_event), .adv_timer_event(adv_timer_event),
    .threshold_select(threshold_select), .monitor_active(monitor_active), .irq_request(irq_request),
    .source_request(source_request), .idle_wake(idle_wake));
  // ====================
  // Infrastructure
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Wake is a one-cycle pulse, so latch it
  always @(posedge pclk)
    if (idle_wake === 1'b1) woke <= 1'b1;
  task test_done;
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (95000) @(posedge pclk);
    failures++;
    test_done();
  end
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask : rdc
  // ====================
  // Scenarios
  task t_access;
    for (int i = 0; i < 12; i++) rdc("reset value", 8'(4 * i), 32'h0);
    for (int i = 0; i < 12; i++) apb(1'b1, 8'(4 * i), 32'hff);
    for (int i = 0; i < 11; i++) rdc("writable bits", 8'(4 * i), {24'h0, MASKS[i]});
    rdc("unmapped", 8'h2c, 32'h0);
    check("irq all set", {31'h0, irq_request}, 32'h1);
    apb(1'b1, OFS_PRIMARY_IRQ_CTRL_A, 32'h7e);
    // Write lands at the access edge; look one edge later
    @(posedge pclk);
    check("irq global off", {31'h0, irq_request}, 32'h0);
    // Groups before summaries, else the summaries set again
    for (int i = 10; i >= 0; i--) apb(1'b1, 8'(4 * i), 32'h0);
  endtask : t_access
  task t_edges;
    logic f;
    for (logic [2:0] c = 0; c < 4; c++)
      for (int v = 0; v < 2; v++)
      begin
        apb(1'b1, OFS_PIN_EDGE_SELECT_LO, {24'h0, {4{c[1:0]}}});
        apb(1'b1, OFS_PIN_EDGE_SELECT_HI, {28'h0, {2{c[1:0]}}});
        pm.pins({6{v == 0}});
        repeat (4) @(posedge pclk);
        f = c[v];
        rdc("pins 0 1", OFS_PRIMARY_IRQ_CTRL_A, f ? 32'h30 : 32'h0);
        rdc("pins 2 3", OFS_GROUP_IRQ_CTRL_D, f ? 32'h30 : 32'h0);
        rdc("pins 4 5", OFS_PRIMARY_IRQ_CTRL_C, f ? 32'hc0 : 32'h0);
        apb(1'b1, OFS_PRIMARY_IRQ_CTRL_A, 32'h0);
        apb(1'b1, OFS_GROUP_IRQ_CTRL_D, 32'h0);
        apb(1'b1, OFS_PRIMARY_IRQ_CTRL_C, 32'h0);
      end
  endtask : t_edges
  task t_events;
    apb(1'b1, OFS_PRIMARY_IRQ_CTRL_A, 32'h09);
    pm.pulse(16'h0001);
    @(posedge pclk);
    check("converter irq", {31'h0, irq_request}, 32'h1);
    apb(1'b1, OFS_GROUP_IRQ_CTRL_B, 32'h04);
    apb(1'b1, OFS_PRIMARY_IRQ_CTRL_B, 32'h02);
    pm.pulse(16'h0400);
    rdc("group summary", OFS_PRIMARY_IRQ_CTRL_B, 32'h22);
    rdc("eeprom flag", OFS_GROUP_IRQ_CTRL_B, 32'h44);
    // Flags are sticky: software clears them itself
    apb(1'b1, OFS_GROUP_IRQ_CTRL_B, 32'h0);
    apb(1'b1, OFS_PRIMARY_IRQ_CTRL_B, 32'h0);
    apb(1'b1, OFS_PRIMARY_IRQ_CTRL_A, 32'h0);
  endtask : t_events
  task t_supply;
    logic [1:0] q;
    int n;
    int lim;
    apb(1'b1, OFS_SUPPLY_MONITOR_CTRL, 32'h15);
    @(posedge pclk);
    check("threshold", {29'h0, threshold_select}, 32'h5);
    sleep_mode <= 1'b1;
    @(posedge pclk);
    check("sleep off", {31'h0, monitor_active}, 32'h0);
    sleep_mode <= 1'b0;
    @(posedge pclk);
    check("monitor on", {31'h0, monitor_active}, 32'h1);
    apb(1'b1, OFS_GROUP_IRQ_CTRL_B, 32'h08);
    for (int k = 0; k < 2; k++)
    begin
      q = k ? 2'd2 : 2'd3;
      lim = k ? QUAL_TICKS_LONG : QUAL_TICKS_SHORT;
      apb(1'b1, OFS_SUPPLY_MONITOR_CTRL, {24'h0, q, 6'h15});
      woke = 1'b0;
      n = 0;
      idle_mode <= 1'b1;
      below_threshold <= 1'b1;
      repeat (3) @(posedge pclk);
      rdc("low supply", OFS_SUPPLY_MONITOR_CTRL, {24'h0, q, 6'h35});
      do
      begin
        apb(1'b0, OFS_GROUP_IRQ_CTRL_B, 32'h0);
        n++;
      end
      while (rd[7] !== 1'b1 && n < 40000);
      // Polling starts six cycles after the output bit rises
      check("qualify", 32'(3 * n + 9 >= (lim - 1) * SLOW_TICK_CYCLES && 3 * n <= lim * SLOW_TICK_CYCLES + 12), 32'h1);
      check("idle wake", {31'h0, woke}, 32'h1);
      below_threshold <= 1'b0;
      idle_mode <= 1'b0;
      apb(1'b1, OFS_GROUP_IRQ_CTRL_B, 32'h08);
      rdc("supply back", OFS_SUPPLY_MONITOR_CTRL, {24'h0, q, 6'h15});
    end
  endtask : t_supply
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    below_threshold = 1'b0;
    sleep_mode = 1'b0;
    idle_mode = 1'b0;
    woke = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_access();
    t_edges();
    t_events();
    t_supply();
    test_done();
  end
endmodule : testbench
